// [inc/tcs_map.vh]
`ifndef TCS_MAP_VH
`define TCS_MAP_VH
// Register word offsets (byte addresses on a 32-bit Wishbone bus)
`define TCS_TIMER_MODE_ADDR    8'h00
`define TCS_TIMER_CTRL_ADDR    8'h04
`define TCS_CLK_CTRL_ADDR      8'h08
`define TCS_T0_COUNT_ADDR      8'h0C
`define TCS_T1_COUNT_ADDR      8'h10
`define TCS_THIRD_CTRL_ADDR    8'h14
`define TCS_THIRD_MODE_ADDR    8'h18
`define TCS_THIRD_COUNT_ADDR   8'h1C
`define TCS_CAPTURE_ADDR       8'h20
// Timer mode register fields (timer zero low nibble, timer one high nibble)
`define TCS_TM_MODE_LO         0
`define TCS_TM_MODE_HI         1
`define TCS_TM_CT0             2
`define TCS_TM_GATE0           3
`define TCS_TM_CT1             6
`define TCS_TM_GATE1           7
// Timer control register fields
`define TCS_TC_RUN0            4
`define TCS_TC_OVF0            5
`define TCS_TC_RUN1            6
`define TCS_TC_OVF1            7
// Clock control register fields
`define TCS_CK_TURBO0          3
`define TCS_CK_TURBO1          4
// Third timer control register fields
`define TCS_T3_CRSEL           0
`define TCS_T3_CT              1
`define TCS_T3_RUN             2
`define TCS_T3_EXEN            3
`define TCS_T3_TXCLK           4
`define TCS_T3_RXCLK           5
`define TCS_T3_EXF             6
`define TCS_T3_OVF             7
// Third timer mode register fields
`define TCS_T3M_UPDN           0
`define TCS_T3M_CAPCLR         3
// Reset values
`define TCS_CLK_CTRL_RST       8'h00
// Prescaler divide counts
`define TCS_DIV_STD            4'hC
`define TCS_DIV_TURBO          4'h4
`define TCS_MACHINE_CYCLE      4'h4
`endif

// [hw/tcs_timer_set.v]
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_timer_set (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // External pins
  input  wire        count_pin_zero,
  input  wire        count_pin_one,
  input  wire        external_interrupt_pin_zero,
  input  wire        external_interrupt_pin_one,
  input  wire        third_count_pin,
  input  wire        trigger_pin,
  // Interrupt requests
  output reg         irq_timer_zero,
  output reg         irq_timer_one,
  output reg         irq_third
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0]  timer_mode_register_ff;          // Mode, select, gate bits
  reg [7:0]  timer_control_register_ff;       // Run bits and flags
  reg [7:0]  clk_ctrl_ff;                     // Turbo selects
  reg [7:0]  t0_low_ff, t0_high_ff;           // Timer zero bytes
  reg [7:0]  t1_low_ff, t1_high_ff;           // Timer one bytes
  reg [7:0]  third_timer_control_register_ff; // Third control
  reg [7:0]  third_timer_mode_register_ff;    // Third mode
  reg [15:0] third_count_ff;                  // Third count
  reg [15:0] capture_ff;                      // Capture pair
  reg [3:0]  mc_cnt_ff;                       // Machine cycle divider
  reg [3:0]  div0_ff, div1_ff, div3_ff;       // Time base dividers
  reg [2:0]  sy_c0_ff, sy_c1_ff, sy_i0_ff, sy_i1_ff, sy_c3_ff, sy_tr_ff; // Pin syncs
  reg        st_c0_ff, st_c1_ff, st_i0_ff, st_i1_ff, st_c3_ff, st_tr_ff; // Agreed levels
  reg        smp_c0_ff, smp_c1_ff, smp_c3_ff, smp_tr_ff; // Machine cycle samples
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Bus address decode, used by read and write paths
  function hit;
    input [7:0] adr;
    input [7:0] want;
    hit = (adr == want);
  endfunction
  // Divider tick: counts down to one then reloads
  function [3:0] div_next;
    input [3:0] cur;
    input       turbo;
    div_next = (cur > 4'h1) ? cur - 4'h1 : (turbo ? `TCS_DIV_TURBO : `TCS_DIV_STD);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Field taps
  wire [1:0] mode0 = timer_mode_register_ff[`TCS_TM_MODE_HI:`TCS_TM_MODE_LO];
  wire [1:0] mode1 = timer_mode_register_ff[`TCS_TM_MODE_HI + 4:`TCS_TM_MODE_LO + 4];
  wire split0 = (mode0 == 2'b11);
  wire ct0 = timer_mode_register_ff[`TCS_TM_CT0];
  wire ct1 = timer_mode_register_ff[`TCS_TM_CT1];
  wire run0 = timer_control_register_ff[`TCS_TC_RUN0];
  wire run1 = timer_control_register_ff[`TCS_TC_RUN1];
  wire crsel = third_timer_control_register_ff[`TCS_T3_CRSEL];
  wire exen = third_timer_control_register_ff[`TCS_T3_EXEN];
  wire baud = third_timer_control_register_ff[`TCS_T3_TXCLK] |
              third_timer_control_register_ff[`TCS_T3_RXCLK];
  wire updn = third_timer_mode_register_ff[`TCS_T3M_UPDN];
  ////////////////////////////////////////////////////////////////////////////
  // Tick generation
  wire mc_tick = (mc_cnt_ff == 4'h1);
  wire tb0 = (div0_ff == 4'h1);
  wire tb1 = (div1_ff == 4'h1);
  wire tb3 = (div3_ff == 4'h1);
  // falling edge between two machine cycle samples
  wire fall0 = mc_tick & smp_c0_ff & ~st_c0_ff;
  wire fall1 = mc_tick & smp_c1_ff & ~st_c1_ff;
  wire fall3 = mc_tick & smp_c3_ff & ~st_c3_ff;
  wire trig_fall = mc_tick & smp_tr_ff & ~st_tr_ff;
  wire en0 = run0 & (~timer_mode_register_ff[`TCS_TM_GATE0] | st_i0_ff);
  // timer one run bit is borrowed while timer zero is split
  wire en1 = (split0 | run1) & (~timer_mode_register_ff[`TCS_TM_GATE1] | st_i1_ff);
  // counted source is clock ticks or pin edges
  wire inc0 = en0 & (ct0 ? fall0 : tb0);
  wire inc1 = en1 & (ct1 ? fall1 : tb1);
  // split high byte counts clock with timer one run bit
  wire inc0h = split0 & run1 & tb0;
  // third timer source, run bit gating
  wire inc3 = third_timer_control_register_ff[`TCS_T3_RUN] &
              (third_timer_control_register_ff[`TCS_T3_CT] ? fall3 : tb3);
  // Writes land on the edge where the master sees ack, never earlier
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and machine cycle sampling
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sy_c0_ff <= 3'h0; sy_c1_ff <= 3'h0; sy_i0_ff <= 3'h0;
      sy_i1_ff <= 3'h0; sy_c3_ff <= 3'h0; sy_tr_ff <= 3'h0;
      st_c0_ff <= 1'b0; st_c1_ff <= 1'b0; st_i0_ff <= 1'b0;
      st_i1_ff <= 1'b0; st_c3_ff <= 1'b0; st_tr_ff <= 1'b0;
      smp_c0_ff <= 1'b0; smp_c1_ff <= 1'b0; smp_c3_ff <= 1'b0; smp_tr_ff <= 1'b0;
      mc_cnt_ff <= `TCS_MACHINE_CYCLE;
    end else begin
      sy_c0_ff <= {sy_c0_ff[1:0], count_pin_zero};
      sy_c1_ff <= {sy_c1_ff[1:0], count_pin_one};
      sy_i0_ff <= {sy_i0_ff[1:0], external_interrupt_pin_zero};
      sy_i1_ff <= {sy_i1_ff[1:0], external_interrupt_pin_one};
      sy_c3_ff <= {sy_c3_ff[1:0], third_count_pin};
      sy_tr_ff <= {sy_tr_ff[1:0], trigger_pin};
      // Level accepted only once stages two and three agree
      if (sy_c0_ff[1] == sy_c0_ff[2]) st_c0_ff <= sy_c0_ff[2];
      if (sy_c1_ff[1] == sy_c1_ff[2]) st_c1_ff <= sy_c1_ff[2];
      if (sy_i0_ff[1] == sy_i0_ff[2]) st_i0_ff <= sy_i0_ff[2];
      if (sy_i1_ff[1] == sy_i1_ff[2]) st_i1_ff <= sy_i1_ff[2];
      if (sy_c3_ff[1] == sy_c3_ff[2]) st_c3_ff <= sy_c3_ff[2];
      if (sy_tr_ff[1] == sy_tr_ff[2]) st_tr_ff <= sy_tr_ff[2];
      mc_cnt_ff <= div_next(mc_cnt_ff, 1'b1);
      // One sample per machine cycle
      if (mc_tick) begin
        smp_c0_ff <= st_c0_ff; smp_c1_ff <= st_c1_ff;
        smp_c3_ff <= st_c3_ff; smp_tr_ff <= st_tr_ff;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Time base dividers; third timer always uses divide by 12 unless turbo zero
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div0_ff <= `TCS_DIV_STD;
      div1_ff <= `TCS_DIV_STD;
      div3_ff <= `TCS_DIV_STD;
    end else begin
      div0_ff <= div_next(div0_ff, clk_ctrl_ff[`TCS_CK_TURBO0]);
      div1_ff <= div_next(div1_ff, clk_ctrl_ff[`TCS_CK_TURBO1]);
      div3_ff <= div_next(div3_ff, clk_ctrl_ff[`TCS_CK_TURBO0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // General timers, mode registers and bus writes
  reg [7:0] n_t0l, n_t0h, n_t1l, n_t1h;
  reg       ovf0_set, ovf1_set, ovf1_own;
  always @* begin
    n_t0l = t0_low_ff; n_t0h = t0_high_ff;
    n_t1l = t1_low_ff; n_t1h = t1_high_ff;
    ovf0_set = 1'b0; ovf1_set = 1'b0; ovf1_own = 1'b0;
    // Timer zero
    if (inc0) begin
      case (mode0)
        2'b00: begin
          n_t0l = {3'h0, t0_low_ff[4:0] + 5'h01};
          if (t0_low_ff[4:0] == 5'h1F) begin
            n_t0h = t0_high_ff + 8'h01;
            ovf0_set = (t0_high_ff == 8'hFF);
          end
        end
        2'b01: begin
          {n_t0h, n_t0l} = {t0_high_ff, t0_low_ff} + 16'h0001;
          ovf0_set = ({t0_high_ff, t0_low_ff} == 16'hFFFF);
        end
        2'b10: begin
          // low byte reloads from high byte
          n_t0l = (t0_low_ff == 8'hFF) ? t0_high_ff : t0_low_ff + 8'h01;
          ovf0_set = (t0_low_ff == 8'hFF);
        end
        default: begin
          n_t0l = t0_low_ff + 8'h01;
          ovf0_set = (t0_low_ff == 8'hFF);
        end
      endcase
    end
    if (inc0h) begin
      n_t0h = t0_high_ff + 8'h01;
      ovf1_set = (t0_high_ff == 8'hFF);
    end
    // Timer one; its split mode freezes it
    if (inc1 && mode1 != 2'b11) begin
      case (mode1)
        2'b00: begin
          n_t1l = {3'h0, t1_low_ff[4:0] + 5'h01};
          if (t1_low_ff[4:0] == 5'h1F) begin
            n_t1h = t1_high_ff + 8'h01;
            ovf1_own = (t1_high_ff == 8'hFF);
          end
        end
        2'b01: begin
          {n_t1h, n_t1l} = {t1_high_ff, t1_low_ff} + 16'h0001;
          ovf1_own = ({t1_high_ff, t1_low_ff} == 16'hFFFF);
        end
        default: begin
          n_t1l = (t1_low_ff == 8'hFF) ? t1_high_ff : t1_low_ff + 8'h01;
          ovf1_own = (t1_low_ff == 8'hFF);
        end
      endcase
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timer_mode_register_ff    <= 8'h00;
      timer_control_register_ff <= 8'h00;
      clk_ctrl_ff <= `TCS_CLK_CTRL_RST;
      t0_low_ff <= 8'h00; t0_high_ff <= 8'h00;
      t1_low_ff <= 8'h00; t1_high_ff <= 8'h00;
    end else begin
      t0_low_ff <= n_t0l; t0_high_ff <= n_t0h;
      t1_low_ff <= n_t1l; t1_high_ff <= n_t1h;
      if (wr && hit(wb_adr_i, `TCS_TIMER_MODE_ADDR)) timer_mode_register_ff <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `TCS_CLK_CTRL_ADDR)) clk_ctrl_ff <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `TCS_T0_COUNT_ADDR)) begin
        t0_low_ff <= wb_dat_i[7:0];
        t0_high_ff <= wb_dat_i[15:8];
      end
      if (wr && hit(wb_adr_i, `TCS_T1_COUNT_ADDR)) begin
        t1_low_ff <= wb_dat_i[7:0];
        t1_high_ff <= wb_dat_i[15:8];
      end
      if (wr && hit(wb_adr_i, `TCS_TIMER_CTRL_ADDR)) timer_control_register_ff <= wb_dat_i[7:0];
      // Hardware set wins over a same-cycle software clear
      if (ovf0_set) timer_control_register_ff[`TCS_TC_OVF0] <= 1'b1;
      // timer one loses its flag while timer zero is split
      if (ovf1_set || (ovf1_own && !split0))
        timer_control_register_ff[`TCS_TC_OVF1] <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Third timer
  reg [15:0] n_cnt3;
  reg        set_ovf3, set_exf3, tog_exf3, n_up;
  always @* begin
    n_cnt3 = third_count_ff;
    set_ovf3 = 1'b0; set_exf3 = 1'b0; tog_exf3 = 1'b0;
    n_up = st_tr_ff;
    if (baud) begin
      // reload on wrap without overflow flag
      if (inc3) n_cnt3 = (third_count_ff == 16'hFFFF) ? capture_ff : third_count_ff + 16'h0001;
      set_exf3 = exen & trig_fall;
    end else if (crsel) begin
      if (inc3) begin
        n_cnt3 = third_count_ff + 16'h0001;
        set_ovf3 = (third_count_ff == 16'hFFFF);
      end
      // capture on trigger edge, flag set
      if (exen & trig_fall) begin
        set_exf3 = 1'b1;
        if (third_timer_mode_register_ff[`TCS_T3M_CAPCLR]) n_cnt3 = 16'h0000;
      end
    end else if (!updn) begin
      // up counter with reload on wrap
      if (inc3) begin
        n_cnt3 = (third_count_ff == 16'hFFFF) ? capture_ff : third_count_ff + 16'h0001;
        set_ovf3 = (third_count_ff == 16'hFFFF);
      end
      // trigger edge reloads and sets external flag
      if (exen & trig_fall) begin
        n_cnt3 = capture_ff;
        set_exf3 = 1'b1;
      end
    end else if (inc3) begin
      // trigger high counts up; low counts down
      if (n_up) begin
        n_cnt3 = (third_count_ff == 16'hFFFF) ? capture_ff : third_count_ff + 16'h0001;
        set_ovf3 = (third_count_ff == 16'hFFFF);
      end else begin
        // down past capture value loads all ones
        n_cnt3 = (third_count_ff == capture_ff) ? 16'hFFFF : third_count_ff - 16'h0001;
        set_ovf3 = (third_count_ff == capture_ff);
      end
      tog_exf3 = set_ovf3;
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      third_timer_control_register_ff <= 8'h00;
      third_timer_mode_register_ff    <= 8'h00;
      third_count_ff <= 16'h0000;
      capture_ff     <= 16'h0000;
    end else begin
      third_count_ff <= n_cnt3;
      if (wr && hit(wb_adr_i, `TCS_THIRD_MODE_ADDR)) third_timer_mode_register_ff <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `TCS_THIRD_COUNT_ADDR)) third_count_ff <= wb_dat_i[15:0];
      if (wr && hit(wb_adr_i, `TCS_CAPTURE_ADDR)) capture_ff <= wb_dat_i[15:0];
      if (!baud && crsel && exen && trig_fall) capture_ff <= third_count_ff;
      if (wr && hit(wb_adr_i, `TCS_THIRD_CTRL_ADDR)) third_timer_control_register_ff <= wb_dat_i[7:0];
      if (set_ovf3) third_timer_control_register_ff[`TCS_T3_OVF] <= 1'b1;
      if (set_exf3) third_timer_control_register_ff[`TCS_T3_EXF] <= 1'b1;
      if (tog_exf3)
        third_timer_control_register_ff[`TCS_T3_EXF] <= ~third_timer_control_register_ff[`TCS_T3_EXF];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and interrupt outputs
  reg [7:0] rd_byte;
  reg [15:0] rd_word;
  always @* begin
    rd_word = 16'h0000;
    rd_byte = 8'h00;
    if (hit(wb_adr_i, `TCS_TIMER_MODE_ADDR)) rd_byte = timer_mode_register_ff;
    if (hit(wb_adr_i, `TCS_TIMER_CTRL_ADDR)) rd_byte = timer_control_register_ff;
    if (hit(wb_adr_i, `TCS_CLK_CTRL_ADDR)) rd_byte = clk_ctrl_ff;
    if (hit(wb_adr_i, `TCS_THIRD_CTRL_ADDR)) rd_byte = third_timer_control_register_ff;
    if (hit(wb_adr_i, `TCS_THIRD_MODE_ADDR)) rd_byte = third_timer_mode_register_ff;
    if (hit(wb_adr_i, `TCS_T0_COUNT_ADDR)) rd_word = {t0_high_ff, t0_low_ff};
    if (hit(wb_adr_i, `TCS_T1_COUNT_ADDR)) rd_word = {t1_high_ff, t1_low_ff};
    if (hit(wb_adr_i, `TCS_THIRD_COUNT_ADDR)) rd_word = third_count_ff;
    if (hit(wb_adr_i, `TCS_CAPTURE_ADDR)) rd_word = capture_ff;
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq_timer_zero <= 1'b0;
      irq_timer_one <= 1'b0;
      irq_third <= 1'b0;
    end else begin
      // Unmapped addresses still acknowledge and read zero
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {16'h0000, rd_word | {8'h00, rd_byte}};
      irq_timer_zero <= timer_control_register_ff[`TCS_TC_OVF0];
      irq_timer_one <= timer_control_register_ff[`TCS_TC_OVF1];
      // external flag masked in up/down mode
      irq_third <= third_timer_control_register_ff[`TCS_T3_OVF] |
                   (third_timer_control_register_ff[`TCS_T3_EXF] & ~(updn & ~crsel & ~baud));
    end
  end
endmodule // tcs_timer_set

// [verification/tcs_timer_set_properties.sv]
`timescale 1ns/1ps
`include "tcs_map.vh"
////////////////////////////////////////////////////////////
// Port-level checker for the timer set
module tcs_timer_set_checker (
  // Clock and reset
  input logic        ref_clk,
  input logic        reset,
  // Wishbone slave side
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // Pins and requests
  input logic        count_pin_zero,
  input logic        count_pin_one,
  input logic        external_interrupt_pin_zero,
  input logic        external_interrupt_pin_one,
  input logic        third_count_pin,
  input logic        trigger_pin,
  input logic        irq_timer_zero,
  input logic        irq_timer_one,
  input logic        irq_third
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Set once software writes the clock control register
  logic clk_wr_ff;
  // Tracks whether turbo bits may legally be non-zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_wr_ff <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `TCS_CLK_CTRL_ADDR) begin
      clk_wr_ff <= 1'b1;
    end
  end
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_unmapped_read_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h20
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_turbo_reset_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `TCS_CLK_CTRL_ADDR && !clk_wr_ff
    |-> wb_dat_o[7:0] == `TCS_CLK_CTRL_RST) else $error("turbo bits not clear after reset");
  a_irq_quiet_reset: assert property ($fell(reset)
    |-> !irq_timer_zero && !irq_timer_one && !irq_third)
    else $error("request high right after reset");
  // Flags of the third timer are cleared by software only, save the EXF toggle in up/down mode
  a_third_irq_hold: assert property ($fell(irq_third) |-> $past(wb_cyc_i && wb_we_i)
    || $past(wb_cyc_i && wb_we_i, 2) || $past(wb_cyc_i && wb_we_i, 3))
    else $error("third request dropped without a write");
  a_zero_irq_hold: assert property ($fell(irq_timer_zero) |-> $past(wb_cyc_i && wb_we_i)
    || $past(wb_cyc_i && wb_we_i, 2) || $past(wb_cyc_i && wb_we_i, 3))
    else $error("timer zero request dropped without a write");
  // Main scenarios reached
  c_write: cover property (wb_ack_o && wb_we_i);
  c_third_irq: cover property ($rose(irq_third));
  c_zero_irq: cover property ($rose(irq_timer_zero));
endmodule // tcs_timer_set_checker

bind tcs_timer_set tcs_timer_set_checker i_chk (.ref_clk(ref_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
  .external_interrupt_pin_zero(external_interrupt_pin_zero),
  .external_interrupt_pin_one(external_interrupt_pin_one),
  .third_count_pin(third_count_pin), .trigger_pin(trigger_pin),
  .irq_timer_zero(irq_timer_zero), .irq_timer_one(irq_timer_one), .irq_third(irq_third));

// [verification/tcs_pin_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Far side: count sources, gate levels and trigger line
module tcs_pin_model (
  // Clock
  input  logic       ref_clk,
  // Pin levels: cnt0, cnt1, gate0, gate1, third cnt, trigger
  output logic [5:0] pins_ff
);
  // Idle high so gates are open and no edge is pending
  initial pins_ff = 6'h3F;
  // two machine cycles per level
  // Slower than needed so every edge is seen once, never twice
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      pins_ff[p] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      pins_ff[p] <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  // Static level for gate and direction pins
  task automatic level(input int p, input logic v);
    @(posedge ref_clk);
    pins_ff[p] <= v;
  endtask
endmodule // tcs_pin_model

// [verification/tcs_timer_set_bench.sv]
`timescale 1ns/1ps
`include "tcs_map.vh"
////////////////////////////////////////////////////////////
// Self-checking bench for the timer set
module tcs_timer_set_bench;
  // Clock, reset and bus drive
  logic        ref_clk, reset, wb_cyc, wb_stb, wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic        wb_ack_o, irq0, irq1, irq3;
  logic [5:0]  pins;
  int          fails, n_tests, ovf, e, v, t;
  int unsigned seed;
  // Third timer rows: control, mode, start, count, flags, trigger
  logic [7:0]  t3_ctl [5] = '{8'h07, 8'h06, 8'h16, 8'h06, 8'h06};
  logic [7:0]  t3_md  [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [15:0] t3_st  [5] = '{16'hFFFE, 16'hFFFE, 16'hFFFE, 16'h1236, 16'hFFFE};
  logic [15:0] t3_ex  [5] = '{16'h0001, 16'h1235, 16'h1235, 16'hFFFF, 16'h1235};
  logic [1:0]  t3_fl  [5] = '{2'h2, 2'h2, 2'h0, 2'h3, 2'h3};
  logic        t3_tr  [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  tcs_timer_set i_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_pin_zero(pins[0]),
    .count_pin_one(pins[1]), .external_interrupt_pin_zero(pins[2]),
    .external_interrupt_pin_one(pins[3]), .third_count_pin(pins[4]),
    .trigger_pin(pins[5]), .irq_timer_zero(irq0), .irq_timer_one(irq1), .irq_third(irq3));
  tcs_pin_model i_pins (.ref_clk(ref_clk), .pins_ff(pins));

  ////////////////////////////////////////////////////////////
  // Free-running 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; waits for ack, bounded so a hang cannot stall
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge ref_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, a, d, 4'hF};
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 40);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (w >= 40) fails++;
  endtask
  // Fixed-seed xorshift
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // General timer model after n counted edges; f reports an overflow
  function automatic int t0_model(input int m, input int v, input int n, output int f);
    int c;
    f = 0;
    repeat (n) begin
      case (m)
        0: begin
          c = ((((v >> 8) << 5) | (v & 'h1F)) + 1) & 'h1FFF;
          f |= (c == 0);
          v = ((c >> 5) << 8) | (c & 'h1F);
        end
        1: begin
          v = (v + 1) & 'hFFFF;
          f |= (v == 0);
        end
        default: begin
          c = (v & 'hFF) + 1;
          if (c == 256) begin
            c = v >> 8;
            f = 1;
          end
          v = (v & 'hFF00) | c;
        end
      endcase
    end
    return v;
  endfunction
  // Verdict and end of run
  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 93621;
    {reset, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = {4'h8, 8'h00, 32'h0, 4'h0};
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    wb(0, `TCS_CLK_CTRL_ADDR, 0);
    check(rd, `TCS_CLK_CTRL_RST);
    wb(1, 8'h40, xs());
    wb(0, 8'h40, 0);
    check(rd, 0);
    // Modes 13-bit, 16-bit, reload, then 16-bit with gate closed
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 'hFF1E : (i == 2) ? 'h80FE : 'hFFFE;
      wb(1, `TCS_TIMER_MODE_ADDR, (i == 3) ? 32'h0D : 32'h04 | i);
      wb(1, `TCS_T0_COUNT_ADDR, v);
      if (i == 3) i_pins.level(2, 1'b0);
      wb(1, `TCS_TIMER_CTRL_ADDR, 32'h10);
      i_pins.pulse(0, 3);
      repeat (8) @(posedge ref_clk);
      e = t0_model((i == 3) ? 1 : i, v, (i == 3) ? 0 : 3, ovf);
      wb(0, `TCS_T0_COUNT_ADDR, 0);
      check(rd, e);
      wb(0, `TCS_TIMER_CTRL_ADDR, 0);
      check(rd[5], ovf);
      check(irq0, ovf);
      i_pins.level(2, 1'b1);
    end
    // Time base turbo then standard
    for (int k = 0; k < 2; k++) begin
      wb(1, `TCS_CLK_CTRL_ADDR, k ? 32'h00 : 32'h08);
      wb(1, `TCS_TIMER_MODE_ADDR, 32'h01);
      wb(1, `TCS_T0_COUNT_ADDR, 0);
      wb(1, `TCS_TIMER_CTRL_ADDR, 32'h10);
      t = int'($time);
      repeat (400) @(posedge ref_clk);
      wb(1, `TCS_TIMER_CTRL_ADDR, 32'h00);
      t = (int'($time) - t) / 50 / (k ? 12 : 4);
      wb(0, `TCS_T0_COUNT_ADDR, 0);
      check(rd >= t - 1 && rd <= t + 1, 1);
    end
    // Split timer zero: timer one free-runs, then frozen while the high byte takes its bits
    for (int i = 0; i < 2; i++) begin
      wb(1, `TCS_TIMER_MODE_ADDR, i ? 32'h33 : 32'h13);
      wb(1, `TCS_T0_COUNT_ADDR, 32'hFF00);
      wb(1, `TCS_T1_COUNT_ADDR, 32'hFFFF);
      wb(1, `TCS_TIMER_CTRL_ADDR, i ? 32'h40 : 32'h00);
      repeat (60) @(posedge ref_clk);
      wb(0, `TCS_T1_COUNT_ADDR, 0);
      check(rd == 'hFFFF, i);
      wb(0, `TCS_TIMER_CTRL_ADDR, 0);
      check(rd[7], i);
      check(rd[5], 0);
      check(irq1, i);
      wb(0, `TCS_T0_COUNT_ADDR, 0);
      check(rd[7:0], 0);
    end
    // Third timer: capture, reload up, baud, down, up
    wb(1, `TCS_CAPTURE_ADDR, 32'h1234);
    for (int i = 0; i < 5; i++) begin
      wb(1, `TCS_THIRD_MODE_ADDR, t3_md[i]);
      wb(1, `TCS_THIRD_COUNT_ADDR, t3_st[i]);
      i_pins.level(5, t3_tr[i]);
      wb(1, `TCS_THIRD_CTRL_ADDR, t3_ctl[i]);
      i_pins.pulse(4, 3);
      repeat (8) @(posedge ref_clk);
      wb(0, `TCS_THIRD_COUNT_ADDR, 0);
      check(rd, t3_ex[i]);
      wb(0, `TCS_THIRD_CTRL_ADDR, 0);
      check(rd[7:6], t3_fl[i]);
      check(irq3, t3_fl[i][1]);
    end
    // Trigger capture, plain then with auto clear
    for (int i = 0; i < 2; i++) begin
      v = xs() & 'hFFFF;
      wb(1, `TCS_THIRD_MODE_ADDR, i ? 32'h08 : 32'h00);
      wb(1, `TCS_THIRD_COUNT_ADDR, v);
      wb(1, `TCS_THIRD_CTRL_ADDR, 32'h0F);
      i_pins.pulse(5, 1);
      repeat (8) @(posedge ref_clk);
      wb(0, `TCS_CAPTURE_ADDR, 0);
      check(rd, v);
      wb(0, `TCS_THIRD_CTRL_ADDR, 0);
      check(rd[6], 1);
      wb(0, `TCS_THIRD_COUNT_ADDR, 0);
      check(rd, i ? 0 : v);
    end
    // Trigger edge forces a reload in up mode
    wb(1, `TCS_THIRD_CTRL_ADDR, 32'h0E);
    wb(1, `TCS_THIRD_COUNT_ADDR, 32'h0077);
    i_pins.pulse(5, 1);
    repeat (8) @(posedge ref_clk);
    wb(0, `TCS_THIRD_COUNT_ADDR, 0);
    check(rd, v);
    // Baud mode: trigger edge raises only the external flag
    wb(1, `TCS_THIRD_CTRL_ADDR, 32'h1C);
    i_pins.pulse(5, 1);
    repeat (8) @(posedge ref_clk);
    wb(0, `TCS_THIRD_CTRL_ADDR, 0);
    check(rd[7:6], 1);
    check(irq3, 1);
    print_verdict();
  end
endmodule // tcs_timer_set_bench
